// >>> src/standby_gpio_params.svh
// constants of the standby pin data block and its common register map
// assumes an 8-bit register port with offsets 00h..1fh
//
// Function
// - input data a: bits 7-6 input pins, 5-0 bidirectional pins, live
// - input data a shows live level, ignoring configuration and out data a
// - writes to input data a and b are ignored entirely
// - out data b loads 03h on power-up or soft reset unless locked
// - out data b bits 1-0 drive output pins; bits 7-2 reserved zero
// - writes latch each out data bit unless its pin lock is set
// - reading out data b returns the latch, not the pin level
// - one requests high per buffer type, zero drives low
// - input data b bits 3-0 show output pins 0,1 and sense pins 2,3
// - offsets 00h to 0bh decode the same in bank 0 and bank 1
`ifndef STANDBY_GPIO_PARAMS_SVH
`define STANDBY_GPIO_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_WAKE_STS_LO  5'h00
`define OFS_WAKE_STS_HI  5'h01
`define OFS_WAKE_EN_LO   5'h02
`define OFS_WAKE_EN_HI   5'h03
`define OFS_WAKE_CFG     5'h04
`define OFS_OUT_DATA_A   5'h08
`define OFS_IN_DATA_A    5'h09
`define OFS_OUT_DATA_B   5'h0a
`define OFS_IN_DATA_B    5'h0b

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define RST_OUT_DATA_A   8'h00
`define RST_OUT_DATA_B   8'h03
`define RST_WAKE_EN      8'h00
`define RST_WAKE_CFG     8'h00
`define MASK_OUT_DATA_A  8'h3f
`define MASK_OUT_DATA_B  8'h03
`define MASK_WAKE_CFG    8'h0f
`define MASK_IN_DATA_B   8'h0f

`endif

// >>> src/standby_gpio_pkg.sv
// types shared by the standby pin data block
// assumes the constants header is included by the design file
package standby_gpio_pkg;

    // ****************************************************************
    // register port request
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // ****************************************************************
    // per-pin configuration, low bits used per pin group
    // ****************************************************************
    typedef struct packed {
        logic [7:0] lock;
        logic [7:0] out_en;
        logic [7:0] open_drain;
    } pin_cfg_s;

    typedef enum logic [1:0] {
        BANK_0,
        BANK_1,
        BANK_2,
        BANK_3
    } bank_e;

endpackage : standby_gpio_pkg

// >>> src/standby_gpio_data_regs.sv
// standby pin data registers with the common wake-up register map
// assumes pins are synchronous to clk_sys_i, bank logic lives elsewhere
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "standby_gpio_params.svh"

module standby_gpio_data_regs
    import standby_gpio_pkg::*;
#(
    parameter int NUM_BIDIR = 6,
    parameter int NUM_OUT   = 2
) (
    // clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 soft_rst_i,
    // register port
    input  wire reg_req_s             req_i,
    output logic [7:0]                rdata_o,
    // configuration from the pin configuration logic
    input  wire logic                 cfg_lock_i,
    input  wire pin_cfg_s             cfg_bidir_i,
    input  wire pin_cfg_s             cfg_out_i,
    // wake events and interrupt
    input  wire logic [15:0]          wake_event_i,
    output logic                      irq_o,
    output logic [1:0]                bank_sel_o,
    // standby pins
    input  wire logic [1:0]           standby_input_pin_i,
    input  wire logic [NUM_BIDIR-1:0] standby_bidir_pin_i,
    output logic [NUM_BIDIR-1:0]      standby_bidir_pin_o,
    output logic [NUM_BIDIR-1:0]      standby_bidir_pin_oe_o,
    input  wire logic [NUM_OUT-1:0]   standby_output_pin_i,
    output logic [NUM_OUT-1:0]        standby_output_pin_o,
    output logic [NUM_OUT-1:0]        standby_output_pin_oe_o,
    input  wire logic [1:0]           standby_sense_pin_i
);

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] wake_event_status_low_r;
    logic [7:0] wake_event_status_high_r;
    logic [7:0] wake_event_enable_low_r;
    logic [7:0] wake_event_enable_high_r;
    logic [7:0] wake_configuration_r;
    logic [7:0] standby_out_data_a_r;
    logic [7:0] standby_out_data_b_r;
    logic [7:0] rdata_nxt;
    logic [7:0] standby_in_data_a;
    logic [7:0] standby_in_data_b;
    logic       wr_hit_sts_lo;
    logic       wr_hit_sts_hi;
    logic       wr_hit_out_a;
    logic       wr_hit_out_b;
    bank_e      bank_sel;

    // ****************************************************************
    // live pin views
    // ****************************************************************
    // no register in between: the pins already arrive synchronous
    assign standby_in_data_a = {standby_input_pin_i,
                                standby_bidir_pin_i[5:0]};
    assign standby_in_data_b = {4'h0, standby_sense_pin_i[1],
                                standby_sense_pin_i[0],
                                standby_output_pin_i[1],
                                standby_output_pin_i[0]};

    // ****************************************************************
    // write decode
    // ****************************************************************
    // bank select is not looked at: 00h..0bh are common to the banks
    // input data offsets get no write hit, so such writes fall away
    assign wr_hit_sts_lo = req_i.wr && req_i.addr == `OFS_WAKE_STS_LO;
    assign wr_hit_sts_hi = req_i.wr && req_i.addr == `OFS_WAKE_STS_HI;
    assign wr_hit_out_a  = req_i.wr && req_i.addr == `OFS_OUT_DATA_A;
    assign wr_hit_out_b  = req_i.wr && req_i.addr == `OFS_OUT_DATA_B;
    assign bank_sel      = bank_e'(wake_configuration_r[1:0]);

    // ****************************************************************
    // wake status, set wins over clear
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_event_status_low_r <= 8'h00;
        end else begin
            wake_event_status_low_r <= (wake_event_status_low_r &
                ~(wr_hit_sts_lo ? req_i.wdata : 8'h00)) |
                wake_event_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_event_status_high_r <= 8'h00;
        end else begin
            wake_event_status_high_r <= (wake_event_status_high_r &
                ~(wr_hit_sts_hi ? req_i.wdata : 8'h00)) |
                wake_event_i[15:8];
        end
    end

    // ****************************************************************
    // wake enables and configuration
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_event_enable_low_r  <= `RST_WAKE_EN;
            wake_event_enable_high_r <= `RST_WAKE_EN;
        end else if (req_i.wr) begin
            if (req_i.addr == `OFS_WAKE_EN_LO) begin
                wake_event_enable_low_r <= req_i.wdata;
            end
            if (req_i.addr == `OFS_WAKE_EN_HI) begin
                wake_event_enable_high_r <= req_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wake_configuration_r <= `RST_WAKE_CFG;
        end else if (req_i.wr && req_i.addr == `OFS_WAKE_CFG) begin
            wake_configuration_r <= req_i.wdata & `MASK_WAKE_CFG;
        end
    end

    // ****************************************************************
    // output data latches
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            standby_out_data_a_r <= `RST_OUT_DATA_A;
        end else if (wr_hit_out_a) begin
            standby_out_data_a_r <= ((standby_out_data_a_r &
                cfg_bidir_i.lock) | (req_i.wdata &
                ~cfg_bidir_i.lock)) & `MASK_OUT_DATA_A;
        end
    end

    // lock held over a reset keeps the latch; pin drivers ignore soft reset and follow the latch, rst_i clears the pin drivers
    always_ff @(posedge clk_sys_i) begin
        if ((rst_i || soft_rst_i) && !cfg_lock_i) begin
            standby_out_data_b_r <= `RST_OUT_DATA_B;
        end else if (wr_hit_out_b && !rst_i && !soft_rst_i) begin
            standby_out_data_b_r <= ((standby_out_data_b_r &
                cfg_out_i.lock) | (req_i.wdata &
                ~cfg_out_i.lock)) & `MASK_OUT_DATA_B;
        end
    end

    // ****************************************************************
    // read mux, one cycle latency
    // ****************************************************************
    always_comb begin
        rdata_nxt = 8'h00;
        case (req_i.addr)
            `OFS_WAKE_STS_LO: rdata_nxt = wake_event_status_low_r;
            `OFS_WAKE_STS_HI: rdata_nxt = wake_event_status_high_r;
            `OFS_WAKE_EN_LO:  rdata_nxt = wake_event_enable_low_r;
            `OFS_WAKE_EN_HI:  rdata_nxt = wake_event_enable_high_r;
            `OFS_WAKE_CFG:    rdata_nxt = wake_configuration_r;
            `OFS_OUT_DATA_A:  rdata_nxt = standby_out_data_a_r;
            `OFS_IN_DATA_A:   rdata_nxt = standby_in_data_a;
            `OFS_OUT_DATA_B:  rdata_nxt = standby_out_data_b_r;
            `OFS_IN_DATA_B:   rdata_nxt = standby_in_data_b;
            default:          rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= req_i.rd ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************************************
    // interrupt and bank select
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |{wake_event_status_low_r & wake_event_enable_low_r,
                       wake_event_status_high_r &
                       wake_event_enable_high_r};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bank_sel_o <= 2'h0;
        end else begin
            bank_sel_o <= bank_sel;
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    // open drain only ever drives low; a one releases the pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BIDIR; gi++) begin : g_bidir
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    standby_bidir_pin_o[gi]    <= 1'b0;
                    standby_bidir_pin_oe_o[gi] <= 1'b0;
                end else begin
                    standby_bidir_pin_o[gi]    <= standby_out_data_a_r[gi];
                    standby_bidir_pin_oe_o[gi] <= cfg_bidir_i.out_en[gi] &&
                        !(cfg_bidir_i.open_drain[gi] &&
                          standby_out_data_a_r[gi]);
                end
            end
        end
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    standby_output_pin_o[gi]    <= 1'b0;
                    standby_output_pin_oe_o[gi] <= 1'b0;
                end else begin
                    standby_output_pin_o[gi]    <= standby_out_data_b_r[gi];
                    standby_output_pin_oe_o[gi] <= cfg_out_i.out_en[gi] &&
                        !(cfg_out_i.open_drain[gi] &&
                          standby_out_data_b_r[gi]);
                end
            end
        end
    endgenerate

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_in_a_live: assert property (
        req_i.rd && req_i.addr == `OFS_IN_DATA_A |=>
        rdata_o == $past(standby_in_data_a))
        else $error("input data a read does not show pins");

    a_in_b_live: assert property (
        req_i.rd && req_i.addr == `OFS_IN_DATA_B |=>
        rdata_o[3:0] == {$past(standby_sense_pin_i),
                         $past(standby_output_pin_i)} &&
        rdata_o[7:4] == 4'h0)
        else $error("input data b read does not show pins");

    a_in_a_ignore_cfg: assert property (
        req_i.rd && req_i.addr == `OFS_IN_DATA_A |=>
        rdata_o[5:0] == $past(standby_bidir_pin_i[5:0]) &&
        rdata_o[7:6] == $past(standby_input_pin_i))
        else $error("input data a depends on configuration");

    a_ro_write_nop: assert property (
        req_i.wr && (req_i.addr == `OFS_IN_DATA_A ||
                     req_i.addr == `OFS_IN_DATA_B) && !soft_rst_i |=>
        $stable(standby_out_data_a_r) && $stable(standby_out_data_b_r) &&
        $stable(wake_configuration_r))
        else $error("write to input data changed state");

    a_soft_rst_load: assert property (
        soft_rst_i && !cfg_lock_i |=> standby_out_data_b_r == `RST_OUT_DATA_B)
        else $error("out data b not loaded on soft reset");

    a_soft_rst_lock: assert property (
        soft_rst_i && cfg_lock_i |=> $stable(standby_out_data_b_r))
        else $error("locked out data b changed on soft reset");

    a_out_b_resv: assert property (
        standby_out_data_b_r[7:2] == 6'h00)
        else $error("reserved out data b bits set");

    // pins sit at their reset value one edge past release, hence the guard
    a_pin_follows: assert property (
        !rst_i |=> standby_output_pin_o == $past(standby_out_data_b_r[1:0]))
        else $error("output pin does not follow latch");

    a_lock_holds: assert property (
        wr_hit_out_a |=> ((standby_out_data_a_r ^
        $past(standby_out_data_a_r)) & $past(cfg_bidir_i.lock)) == 8'h00)
        else $error("locked out data a bit changed");

    a_write_latch: assert property (
        wr_hit_out_b && !soft_rst_i && cfg_out_i.lock[1:0] == 2'b00 |=>
        standby_out_data_b_r[1:0] == $past(req_i.wdata[1:0]))
        else $error("out data b write not latched");

    a_out_b_read: assert property (
        req_i.rd && req_i.addr == `OFS_OUT_DATA_B |=>
        rdata_o == $past(standby_out_data_b_r))
        else $error("out data b read not the latch");

    a_od_release: assert property (
        cfg_out_i.open_drain[0] && standby_out_data_b_r[0] |=>
        !standby_output_pin_oe_o[0])
        else $error("open drain pin driven high");

    a_pp_drive: assert property (
        !rst_i && cfg_out_i.out_en[0] && !cfg_out_i.open_drain[0] |=>
        standby_output_pin_oe_o[0])
        else $error("push-pull pin not driven");

    a_bank_common: assert property (
        req_i.rd && req_i.addr == `OFS_OUT_DATA_A |=>
        rdata_o == $past(standby_out_data_a_r))
        else $error("common register read depends on bank");

    a_resv_zero: assert property (
        req_i.rd && req_i.addr > `OFS_IN_DATA_B |=> rdata_o == 8'h00)
        else $error("reserved offset reads nonzero");

    a_idle_rdata: assert property (
        !req_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");

    a_sticky_set: assert property (
        wake_event_i[0] |=> wake_event_status_low_r[0])
        else $error("wake event lost");

    a_status_clear: assert property (
        wr_hit_sts_lo && req_i.wdata[0] && !wake_event_i[0] |=>
        !wake_event_status_low_r[0])
        else $error("status bit not cleared by writing one");

    a_irq_level: assert property (
        |{wake_event_status_low_r & wake_event_enable_low_r,
          wake_event_status_high_r & wake_event_enable_high_r} |=> irq_o)
        else $error("unmasked status without interrupt");

    a_bidir_drive: assert property (
        !rst_i && cfg_bidir_i.out_en[0] && !cfg_bidir_i.open_drain[0] |=>
        standby_bidir_pin_oe_o[0])
        else $error("push-pull bidirectional pin not driven");

    c_soft_rst_lock: cover property (soft_rst_i && cfg_lock_i);
    c_bank1_read: cover property (
        bank_sel == BANK_1 && req_i.rd && req_i.addr == `OFS_IN_DATA_A);
    c_locked_write: cover property (wr_hit_out_b && |cfg_out_i.lock[1:0]);
    c_irq: cover property (!irq_o ##1 irq_o);
    c_soft_rst_load: cover property (soft_rst_i && !cfg_lock_i);

endmodule : standby_gpio_data_regs

// >>> sim/standby_pin_board.sv
// board model of the standby pins, one resolved level per pin
// assumes oe high while the block drives, board_drv is the board side
`timescale 1ns/10ps

module standby_pin_board #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_o,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] board_drv,
    output logic      [W-1:0] level
);
    // released pins follow the board, never the last driven value
    assign level = (pin_oe & pin_o) | (~pin_oe & board_drv);
endmodule : standby_pin_board

// >>> sim/testbench.sv
// self-checking bench of the standby pin data registers
// assumes the board model, default pin counts, 125 MHz clock
`timescale 1ns/10ps
`include "standby_gpio_params.svh"

module testbench;
    import standby_gpio_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        soft_rst_i = 1'b0;
    logic        cfg_lock_i = 1'b0;
    reg_req_s    req_i = '0;
    pin_cfg_s    cfg_bidir_i = '0;
    pin_cfg_s    cfg_out_i = '0;
    logic [15:0] wake_event_i = '0;
    logic [1:0]  in_pin = '0;
    logic [1:0]  sense_pin = '0;
    logic [7:0]  board_drv = '0;
    logic [7:0]  rdata_o, oa, ob, d, lk, od;
    logic        irq_o;
    logic [1:0]  bank_sel_o, out_o, out_oe;
    logic [5:0]  bidir_o, bidir_oe;
    logic [7:0]  level;
    logic [4:0]  ra;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    standby_gpio_data_regs standby_gpio_data_regs_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .req_i(req_i), .rdata_o(rdata_o), .cfg_lock_i(cfg_lock_i),
        .cfg_bidir_i(cfg_bidir_i), .cfg_out_i(cfg_out_i),
        .wake_event_i(wake_event_i), .irq_o(irq_o),
        .bank_sel_o(bank_sel_o), .standby_input_pin_i(in_pin),
        .standby_bidir_pin_i(level[5:0]), .standby_bidir_pin_o(bidir_o),
        .standby_bidir_pin_oe_o(bidir_oe),
        .standby_output_pin_i(level[7:6]), .standby_output_pin_o(out_o),
        .standby_output_pin_oe_o(out_oe), .standby_sense_pin_i(sense_pin)
    );

    standby_pin_board #(.W(8)) standby_pin_board_i (
        .pin_o({out_o, bidir_o}), .pin_oe({out_oe, bidir_oe}),
        .board_drv(board_drv), .level(level)
    );

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] exp_latch(input logic [7:0] old,
        input logic [7:0] v, input logic [7:0] lock, input logic [7:0] m);
        return ((old & lock) | (v & ~lock)) & m;
    endfunction : exp_latch

    task automatic finish_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys_i);
        req_i <= '0;
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req_i <= '0;
        #1;
        chk(rdata_o, exp);
    endtask : rd_chk

    task automatic pulse_event(input logic [15:0] ev);
        @(posedge clk_sys_i);
        wake_event_i <= ev;
        @(posedge clk_sys_i);
        wake_event_i <= '0;
    endtask : pulse_event

    // timeout well beyond the roughly 600 cycles the run needs
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(29));
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        ob = `RST_OUT_DATA_B;
        oa = `RST_OUT_DATA_A;
        chk({6'h00, out_o}, ob);
        rd_chk(`OFS_OUT_DATA_B, ob);
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom);
            lk = 8'($urandom);
            @(posedge clk_sys_i);
            cfg_out_i.lock <= lk;
            cfg_bidir_i.lock <= lk;
            board_drv <= 8'($urandom);
            in_pin <= 2'($urandom);
            sense_pin <= 2'($urandom);
            wr(`OFS_OUT_DATA_B, d);
            ob = exp_latch(ob, d, lk, `MASK_OUT_DATA_B);
            rd_chk(`OFS_OUT_DATA_B, ob);
            wr(`OFS_OUT_DATA_A, ~d);
            oa = exp_latch(oa, ~d, lk, `MASK_OUT_DATA_A);
            rd_chk(`OFS_OUT_DATA_A, oa);
            wr(`OFS_IN_DATA_A, d);
            wr(`OFS_IN_DATA_B, ~d);
            rd_chk(`OFS_IN_DATA_A, {in_pin, board_drv[5:0]});
            rd_chk(`OFS_IN_DATA_B, {4'h0, sense_pin, board_drv[7:6]});
            chk({6'h00, out_o}, ob);
            chk({2'h0, bidir_o}, oa);
            ra = (i % 2 == 1) ? 5'(5 + i % 3) : 5'(12 + i % 7);
            wr(ra, d);
            rd_chk(ra, 8'h00);
        end
        // driven pins, random buffer type on the output pins
        od = 8'($urandom);
        @(posedge clk_sys_i);
        cfg_out_i <= '{lock: 8'h00, out_en: 8'h03, open_drain: od};
        cfg_bidir_i <= '{lock: 8'h00, out_en: 8'h3f, open_drain: 8'h00};
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk({6'h00, out_oe}, ~(od & ob) & 8'h03);
        chk({2'h0, bidir_oe}, 8'h3f);
        rd_chk(`OFS_IN_DATA_A, {in_pin, oa[5:0]});
        rd_chk(`OFS_IN_DATA_B, {4'h0, sense_pin,
            (od[1:0] & ob[1:0] & board_drv[7:6]) | (~od[1:0] & ob[1:0])});
        // both banks decode the common map alike
        for (int b = 0; b < 2; b++) begin
            wr(`OFS_WAKE_CFG, 8'(b));
            rd_chk(`OFS_WAKE_CFG, 8'(b));
            chk({6'h00, bank_sel_o}, 8'(b));
            wr(`OFS_OUT_DATA_B, 8'(b + 1));
            ob = 8'(b + 1);
            rd_chk(`OFS_OUT_DATA_B, ob);
            rd_chk(`OFS_OUT_DATA_A, oa);
            rd_chk(`OFS_IN_DATA_A, {in_pin, oa[5:0]});
        end
        // sticky status, mask and write-one clear
        pulse_event(16'h0001);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        rd_chk(`OFS_WAKE_STS_LO, 8'h01);
        wr(`OFS_WAKE_EN_LO, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h01);
        wr(`OFS_WAKE_STS_LO, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({7'h00, irq_o}, 8'h00);
        rd_chk(`OFS_WAKE_STS_LO, 8'h00);
        pulse_event(16'h8000);
        rd_chk(`OFS_WAKE_STS_HI, 8'h80);
        wr(`OFS_WAKE_STS_HI, 8'h80);
        rd_chk(`OFS_WAKE_STS_HI, 8'h00);
        // soft reset and power-up reset against the lock
        @(posedge clk_sys_i);
        cfg_lock_i <= 1'b1;
        wr(`OFS_OUT_DATA_B, 8'h00);
        soft_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b0;
        rd_chk(`OFS_OUT_DATA_B, 8'h00);
        @(posedge clk_sys_i);
        cfg_lock_i <= 1'b0;
        soft_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_rst_i <= 1'b0;
        rd_chk(`OFS_OUT_DATA_B, `RST_OUT_DATA_B);
        wr(`OFS_OUT_DATA_B, 8'h02);
        cfg_lock_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_chk(`OFS_OUT_DATA_B, 8'h02);
        chk({6'h00, out_o}, 8'h02);
        finish_test();
    end
endmodule : testbench
